// File: src/logger_pkg.sv
package logger_pkg;
  // Scan timebase and clock
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned SCAN_LONG_S     = 60;
  localparam int unsigned SCAN_SHORT_S    = 10;
  localparam longint unsigned SCAN_LONG_CYC  = 64'(CLK_HZ) * SCAN_LONG_S;
  localparam longint unsigned SCAN_SHORT_CYC = 64'(CLK_HZ) * SCAN_SHORT_S;
  localparam int unsigned MIN_INTERVAL_MIN = 1;
  localparam int unsigned MAX_INTERVAL_MIN = 24 * 60;
  // Storage sizes
  localparam int unsigned NUM_CHAN   = 9;
  localparam int unsigned NUM_TABLES = 3;
  localparam int unsigned NUM_PROGS  = 9;
  localparam int unsigned INTER_LOCS = 64;
  localparam int unsigned FINAL_LOCS = 608;
  localparam int unsigned NUM_BIN_IN = 2;
  localparam int unsigned NUM_OUTS   = 4;
  // Pulse counter ceilings
  localparam logic [11:0] CNT8_MAX = 12'hfff;
  localparam logic [11:0] CNT9_MAX = 12'h00f;
  // AHB-Lite register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_KEY      = 8'h08;
  localparam logic [7:0] REG_DISPLAY  = 8'h0c;
  localparam logic [7:0] REG_CHSEL    = 8'h10;
  localparam logic [7:0] REG_MULT     = 8'h14;
  localparam logic [7:0] REG_OFFS     = 8'h18;
  localparam logic [7:0] REG_TBLSEL   = 8'h1c;
  localparam logic [7:0] REG_TBLINT   = 8'h20;
  localparam logic [7:0] REG_TBLPROG  = 8'h24;
  localparam logic [7:0] REG_TBLACT   = 8'h28;
  localparam logic [7:0] REG_OUTCTL   = 8'h2c;
  localparam logic [7:0] REG_FINADDR  = 8'h30;
  localparam logic [7:0] REG_FINDATA  = 8'h34;
  localparam logic [7:0] REG_INDATA   = 8'h38;
  // Control fields
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_SHORT_BIT = 1;
  // Program entry: [3:0] op, [7:4] chan, [13:8] inter slot, [15:14] out
  localparam logic [3:0] OP_NONE   = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h1;
  localparam logic [3:0] OP_AVG    = 4'h2;
  localparam logic [3:0] OP_SUM    = 4'h3;
  localparam logic [3:0] OP_MAX    = 4'h4;
  localparam logic [3:0] OP_MIN    = 4'h5;
  localparam logic [3:0] OP_SETPT  = 4'h6;
  localparam logic [3:0] OP_TIMED  = 4'h7;
  // Keypad codes
  localparam logic [4:0] KEY_STAR = 5'h0a;
  // Display blank nibble
  localparam logic [3:0] DIG_BLANK = 4'hf;

  typedef struct packed {
    logic [1:0]  out;
    logic [5:0]  slot;
    logic [3:0]  chan;
    logic [3:0]  op;
  } prog_t;

  typedef struct packed {
    logic [7:0]  id;     // Two BCD digits
    logic [15:0] data;   // Four BCD digits, f = blank
  } display_t;

  typedef enum logic [3:0] {
    KS_IDLE = 4'b0001,
    KS_WAIT = 4'b0010,
    KS_MODE = 4'b0100,
    KS_HOLD = 4'b1000
  } key_state_t;

  typedef enum logic [3:0] {
    PS_IDLE  = 4'b0001,
    PS_SCAN  = 4'b0010,
    PS_PROG  = 4'b0100,
    PS_FLUSH = 4'b1000
  } proc_state_t;
endpackage : logger_pkg

// File: src/data_logging_sequencer.sv
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
// Function
// - Scan all channels each scan interval
// - Scale reading by multiplier and offset
// - Three tables, interval plus nine programs
// - Table interval from 1 minute to 24h
// - Average sums scans then divides at end
// - Sixty-four shared intermediate locations
// - Final writes only at interval expiry
// - 608-point final store wraps over oldest
// - Star shows 00:0000, next digit is mode
// - Mode number shown in ID field
// - Data field blank for modes 1-6, shows pointer for 7-9, stays 0000 for 0
// - Mode digits map to logger functions
// - Binary inputs active high
// - Four outputs, timed and set-point control
// - Pulse counters saturate, cleared by scan
module data_logging_sequencer
  import logger_pkg::*;
#(
  parameter longint unsigned SCAN_LONG  = SCAN_LONG_CYC,
  parameter longint unsigned SCAN_SHORT = SCAN_SHORT_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  input  wire logic [NUM_CHAN*16-1:0] raw_i,
  input  wire logic                  pulse8_i,
  input  wire logic                  pulse9_i,
  input  wire logic [NUM_BIN_IN-1:0] bin_in_i,
  output logic      [NUM_OUTS-1:0]   ctl_out_o,
  output display_t                   display_o,
  output logic      [3:0]            mode_o
);
  // Storage arrays
  logic signed [15:0] mult_mem [NUM_CHAN];
  logic signed [15:0] offs_mem [NUM_CHAN];
  logic signed [15:0] engineering_units [NUM_CHAN];
  logic signed [31:0] inter_mem [INTER_LOCS];
  logic [15:0]        scans_mem [INTER_LOCS];
  logic [15:0]        final_mem [FINAL_LOCS];
  prog_t              prog_mem [NUM_TABLES][NUM_PROGS];
  logic [10:0]        tbl_int [NUM_TABLES];
  logic [10:0]        tbl_cnt [NUM_TABLES];
  logic [NUM_TABLES-1:0] tbl_act;
  logic [NUM_TABLES-1:0] due;
  logic [6:0]         tbl_need [NUM_TABLES];

  // Bus capture
  logic        ap_wr;
  logic [7:0]  ap_addr;
  logic [31:0] ctrl;
  logic [3:0]  chsel;
  logic [1:0]  tsel;
  logic [3:0]  psel;
  logic [9:0]  fin_addr;
  logic [9:0]  fin_ptr;
  logic        wrapped, cfg_err;
  logic [11:0] cnt8, cnt9;
  logic [63:0] scan_cnt;
  logic [5:0]  sec_cnt;
  key_state_t  ks;
  proc_state_t ps;
  logic [3:0]  pch;
  logic [1:0]  ptab;
  logic [3:0]  pidx;
  logic        p_flush;
  logic [NUM_OUTS-1:0] timed_on;
  logic [NUM_OUTS-1:0] ctl_hold;

  wire bus_req = hsel_i & hready_i & htrans_i[1];
  wire wr_cyc  = ap_wr;
  wire [63:0] scan_len = ctrl[CTRL_SHORT_BIT] ? SCAN_SHORT : SCAN_LONG;
  wire scan_tick = ctrl[CTRL_RUN_BIT] & (scan_cnt == scan_len - 64'd1);
  wire [5:0] scans_per_min = ctrl[CTRL_SHORT_BIT] ? 6'd6 : 6'd1;
  wire min_tick = scan_tick & (sec_cnt == scans_per_min - 6'd1);

  // Slot demand per table; average needs two words but shares one slot
  function automatic logic [6:0] demand(input int t);
    logic [6:0] n;
    n = 7'd0;
    for (int p = 0; p < NUM_PROGS; p++)
      if (prog_mem[t][p].op != OP_NONE) n = n + 7'd1;
    return n;
  endfunction : demand

  wire [8:0] need_total = 9'(tbl_need[0] & {7{tbl_act[0]}})
                        + 9'(tbl_need[1] & {7{tbl_act[1]}})
                        + 9'(tbl_need[2] & {7{tbl_act[2]}});
  wire [6:0] new_need = demand(int'(tsel));
  wire [8:0] cand_total = need_total
                        - 9'(tbl_need[tsel] & {7{tbl_act[tsel]}})
                        + 9'(new_need);
  wire act_ok = cand_total <= 9'(INTER_LOCS);

  // Current program decode
  prog_t cur;
  assign cur = prog_mem[ptab][pidx];
  wire signed [15:0] cur_val = engineering_units[cur.chan];
  wire signed [31:0] cur_acc = inter_mem[cur.slot];
  wire [15:0] cur_n = scans_mem[cur.slot];
  wire signed [15:0] avg_q = (cur_n == 16'd0) ? 16'sd0 :
                            16'(cur_acc / $signed({16'd0, cur_n}));
  wire [15:0] fin_val = (cur.op == OP_AVG) ? avg_q : cur_acc[15:0];
  wire emit = p_flush && (cur.op inside {OP_SAMPLE, OP_AVG, OP_SUM,
                                         OP_MAX, OP_MIN});
  wire signed [31:0] scaled = 32'(($signed(raw_i[pch*16 +: 16]) *
                              mult_mem[pch]) + 32'(offs_mem[pch]));

  // Read selection decoded from the address phase itself
  wire [7:0]  rd_addr = haddr_i[7:0];
  wire [31:0] rd_data =
    (rd_addr == REG_CTRL)    ? ctrl :
    (rd_addr == REG_STATUS)  ? {15'd0, cfg_err, wrapped, tbl_act,
                                 bin_in_i, fin_ptr} :
    (rd_addr == REG_DISPLAY) ? {8'd0, display_o} :
    (rd_addr == REG_TBLINT)  ? {21'd0, tbl_int[tsel]} :
    (rd_addr == REG_TBLPROG) ? {16'd0, prog_mem[tsel][psel]} :
    (rd_addr == REG_FINADDR) ? {22'd0, fin_addr} :
    (rd_addr == REG_FINDATA) ? {16'd0, final_mem[fin_addr]} :
    (rd_addr == REG_INDATA)  ? {16'd0, engineering_units[chsel]} :
    (rd_addr == REG_OUTCTL)  ? {28'd0, ctl_out_o} : 32'd0;

  // AHB address phase capture; zero wait states, always OKAY
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'd0;
    end else begin
      ap_wr <= bus_req & hwrite_i;
      if (bus_req) ap_addr <= haddr_i[7:0];
      // Latched at the address edge: a write landing that edge reads old
      hrdata_o <= (bus_req & ~hwrite_i) ? rd_data : 32'd0;
    end
  end

  // Pointer shown as four BCD digits on the data field
  function automatic logic [15:0] to_bcd(input logic [9:0] v);
    return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10),
            4'(v % 10)};
  endfunction : to_bcd

  // Config registers written by software
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= 32'd0;
      chsel <= 4'd0;
      tsel <= 2'd0;
      psel <= 4'd0;
      fin_addr <= 10'd0;
      ctl_hold <= '0;
    end else if (wr_cyc) begin
      if (ap_addr == REG_CTRL) ctrl <= {30'd0, hwdata_i[1:0]};
      else if (ap_addr == REG_CHSEL && hwdata_i[3:0] < 4'(NUM_CHAN))
        chsel <= hwdata_i[3:0];
      else if (ap_addr == REG_TBLSEL && hwdata_i[1:0] < 2'(NUM_TABLES)) begin
        tsel <= hwdata_i[1:0];
        psel <= (hwdata_i[11:8] < 4'(NUM_PROGS)) ? hwdata_i[11:8] : 4'd0;
      end
      else if (ap_addr == REG_FINADDR && hwdata_i[9:0] < 10'(FINAL_LOCS))
        fin_addr <= hwdata_i[9:0];
      else if (ap_addr == REG_OUTCTL) ctl_hold <= hwdata_i[3:0];
    end
  end

  // Input table scaling factors
  always_ff @(posedge mclk_i) begin
    if (wr_cyc && ap_addr == REG_MULT) mult_mem[chsel] <= hwdata_i[15:0];
    if (wr_cyc && ap_addr == REG_OFFS) offs_mem[chsel] <= hwdata_i[15:0];
  end

  // Output tables; edits refused while the table is active
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tbl_act <= '0;
      cfg_err <= 1'b0;
      for (int t = 0; t < NUM_TABLES; t++) begin
        tbl_int[t] <= 11'(MIN_INTERVAL_MIN);
        tbl_need[t] <= 7'd0;
      end
    end else if (wr_cyc && !tbl_act[tsel]) begin
      if (ap_addr == REG_TBLINT && hwdata_i[10:0] >= 11'(MIN_INTERVAL_MIN)
          && hwdata_i[10:0] <= 11'(MAX_INTERVAL_MIN))
        tbl_int[tsel] <= hwdata_i[10:0];
      else if (ap_addr == REG_TBLPROG)
        prog_mem[tsel][psel] <= hwdata_i[15:0];
      else if (ap_addr == REG_TBLACT && hwdata_i[0]) begin
        if (act_ok) begin
          tbl_act[tsel] <= 1'b1;
          tbl_need[tsel] <= new_need;
          cfg_err <= 1'b0;
        end else cfg_err <= 1'b1;
      end
    end else if (wr_cyc && ap_addr == REG_TBLACT && !hwdata_i[0])
      tbl_act[tsel] <= 1'b0;
  end

  // Scan timebase and minute counter
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_cnt <= 64'd0;
      sec_cnt <= 6'd0;
    end else if (!ctrl[CTRL_RUN_BIT]) begin
      scan_cnt <= 64'd0;
      sec_cnt <= 6'd0;
    end else begin
      scan_cnt <= scan_tick ? 64'd0 : scan_cnt + 64'd1;
      if (scan_tick) sec_cnt <= min_tick ? 6'd0 : sec_cnt + 6'd1;
    end
  end

  // Pulse counters saturate; read-and-clear by the scan
  // Cleared on the very edge the scan reads them; a coincident pulse stays
  wire clr_cnt8 = (ps == PS_SCAN) && (pch == 4'd7);
  wire clr_cnt9 = (ps == PS_SCAN) && (pch == 4'd8);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt8 <= 12'd0;
      cnt9 <= 12'd0;
    end else begin
      if (clr_cnt8) cnt8 <= {11'd0, pulse8_i};
      else if (pulse8_i && cnt8 != CNT8_MAX) cnt8 <= cnt8 + 12'd1;
      if (clr_cnt9) cnt9 <= {11'd0, pulse9_i};
      else if (pulse9_i && cnt9 != CNT9_MAX) cnt9 <= cnt9 + 12'd1;
    end
  end

  // Scan, then per table run its programs, then flush that table if expired
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ps <= PS_IDLE;
      pch <= 4'd0;
      ptab <= 2'd0;
      pidx <= 4'd0;
      p_flush <= 1'b0;
      due <= '0;
      fin_ptr <= 10'd0;
      wrapped <= 1'b0;
      timed_on <= '0;
      for (int t = 0; t < NUM_TABLES; t++) tbl_cnt[t] <= 11'd0;
    end else begin
      case (ps)
        PS_IDLE: begin
          pch <= 4'd0;
          if (scan_tick) begin
            ps <= PS_SCAN;
            for (int t = 0; t < NUM_TABLES; t++)
              if (min_tick && tbl_act[t]) begin
                due[t] <= (tbl_cnt[t] + 11'd1 >= tbl_int[t]);
                tbl_cnt[t] <= (tbl_cnt[t] + 11'd1 >= tbl_int[t]) ?
                              11'd0 : tbl_cnt[t] + 11'd1;
              end else due[t] <= 1'b0;
          end
        end
        PS_SCAN: begin
          if (pch == 4'd7) engineering_units[pch] <= 16'(cnt8);
          else if (pch == 4'd8) engineering_units[pch] <= 16'(cnt9);
          else engineering_units[pch] <= scaled[15:0];
          if (pch == 4'(NUM_CHAN - 1)) begin
            ps <= PS_PROG;
            ptab <= 2'd0;
            pidx <= 4'd0;
            p_flush <= 1'b0;
          end else pch <= pch + 4'd1;
        end
        PS_PROG, PS_FLUSH: begin
          if (tbl_act[ptab]) begin
            if (!p_flush) begin
              case (cur.op)
                OP_SAMPLE: inter_mem[cur.slot] <= 32'(cur_val);
                OP_AVG, OP_SUM: begin
                  inter_mem[cur.slot] <= cur_acc + 32'(cur_val);
                  scans_mem[cur.slot] <= cur_n + 16'd1;
                end
                OP_MAX: if (cur_n == 16'd0 || 32'(cur_val) > cur_acc) begin
                  inter_mem[cur.slot] <= 32'(cur_val);
                  scans_mem[cur.slot] <= 16'd1;
                end
                OP_MIN: if (cur_n == 16'd0 || 32'(cur_val) < cur_acc) begin
                  inter_mem[cur.slot] <= 32'(cur_val);
                  scans_mem[cur.slot] <= 16'd1;
                end
                OP_SETPT: timed_on[cur.out] <= (cur_val > 16'sd0);
                OP_TIMED: if (due[ptab]) timed_on[cur.out] <=
                                           ~timed_on[cur.out];
                default: ;
              endcase
            end else if (emit) begin
              final_mem[fin_ptr] <= fin_val;
              inter_mem[cur.slot] <= 32'd0;
              scans_mem[cur.slot] <= 16'd0;
              if (fin_ptr == 10'(FINAL_LOCS - 1)) begin
                fin_ptr <= 10'd0;
                wrapped <= 1'b1;
              end else fin_ptr <= fin_ptr + 10'd1;
            end
          end
          if (pidx != 4'(NUM_PROGS - 1)) pidx <= pidx + 4'd1;
          else begin
            pidx <= 4'd0;
            if (!p_flush && due[ptab]) p_flush <= 1'b1;
            else begin
              p_flush <= 1'b0;
              if (ptab == 2'(NUM_TABLES - 1)) ps <= PS_IDLE;
              else ptab <= ptab + 2'd1;
            end
          end
        end
        default: ps <= PS_IDLE;
      endcase
    end
  end

  // Control outputs; binary inputs are active high
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) ctl_out_o <= '0;
    else ctl_out_o <= timed_on | ctl_hold;
  end

  // Keypad mode entry; key codes written over the bus
  wire key_wr = wr_cyc && ap_addr == REG_KEY;
  wire [4:0] key = hwdata_i[4:0];
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ks <= KS_IDLE;
      mode_o <= 4'd0;
      display_o <= '{id: 8'h00, data: 16'h0000};
    end else begin
      case (ks)
        KS_IDLE, KS_HOLD: if (key_wr && key == KEY_STAR) begin
          ks <= KS_WAIT;
          display_o <= '{id: 8'h00, data: 16'h0000};
        end
        KS_WAIT: if (key_wr && key <= 5'd9) begin
          mode_o <= key[3:0];
          ks <= KS_MODE;
        end
        KS_MODE: begin
          ks <= KS_HOLD;
          display_o.id <= {4'd0, mode_o};
          if (mode_o >= 4'd7)
            display_o.data <= to_bcd(fin_ptr);
          else if (mode_o != 4'd0)
            display_o.data <= {4{DIG_BLANK}};
        end
        default: ks <= KS_IDLE;
      endcase
    end
  end
endmodule : data_logging_sequencer

// File: tb/sequencer_monitor.sv
`timescale 1ns/1ns
module sequencer_monitor
  import logger_pkg::*;
(
  input wire logic                mclk_i,
  input wire logic                rstn_i,
  input wire logic                hsel_i,
  input wire logic [31:0]         haddr_i,
  input wire logic [1:0]          htrans_i,
  input wire logic                hwrite_i,
  input wire logic [31:0]         hwdata_i,
  input wire logic                hready_i,
  input wire logic                hreadyout_o,
  input wire logic                hresp_o,
  input wire logic [NUM_OUTS-1:0] ctl_out_o,
  input wire display_t            display_o,
  input wire logic [3:0]          mode_o
);
  logic       key_ap;
  logic       armed;
  logic [3:0] key_last;
  wire        star_wr  = key_ap && hwdata_i[4:0] == KEY_STAR;
  wire        digit_wr = key_ap && hwdata_i[4:0] <= 5'h09;

  // Key write seen in address phase, its value taken in data phase
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_ap   <= 1'b0;
      armed    <= 1'b0;
      key_last <= 4'h0;
    end else begin
      key_ap <= hsel_i && hready_i && htrans_i[1] && hwrite_i
                && haddr_i[7:0] == REG_KEY;
      if (key_ap) begin
        armed    <= star_wr;
        key_last <= hwdata_i[3:0];
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  zero_wait_a: assert property (hreadyout_o)
    else $error("slave inserted a wait state");
  okay_resp_a: assert property (!hresp_o)
    else $error("slave gave an error response");
  reset_view_a: assert property ($rose(rstn_i) |->
    display_o == 24'h000000 && mode_o == 4'h0 && ctl_out_o == 4'h0)
    else $error("outputs not at reset values");
  star_zero_a: assert property (star_wr |-> ##[1:3] display_o == 24'h0)
    else $error("star key did not show all zeros");
  digit_mode_a: assert property (armed && digit_wr |=> ##[0:2] mode_o == key_last)
    else $error("digit after star not taken as mode");
  mode_id_a: assert property ($changed(mode_o) && mode_o != 4'h0 |->
    ##[0:2] display_o.id == {4'h0, mode_o})
    else $error("mode number missing from id field");
  blank_data_a: assert property ($changed(mode_o) && mode_o inside {[1:6]}
    |-> ##[0:2] display_o.data == 16'hffff)
    else $error("data field not blank");
  ptr_data_a: assert property ($changed(mode_o) && mode_o >= 4'h7 |->
    ##[0:2] display_o.data[15:8] < 8'h07 && display_o.data[7:4] < 4'ha)
    else $error("data field does not hold a pointer");

  cover property (star_wr);
  cover property ($changed(mode_o) && mode_o == 4'h7);
  cover property (ctl_out_o == 4'hf);
endmodule : sequencer_monitor

bind data_logging_sequencer sequencer_monitor mon_u (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .ctl_out_o(ctl_out_o), .display_o(display_o), .mode_o(mode_o));

// File: tb/sensor_model.sv
`timescale 1ns/1ns
module sensor_model (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  output logic      [143:0] raw_o,
  output logic              pulse8_o,
  output logic              pulse9_o,
  output logic      [1:0]   bin_o
);
  // Readings wander every cycle so no stale value passes for a fresh one
  initial begin
    raw_o    = '0;
    pulse8_o = 1'b0;
    pulse9_o = 1'b0;
    bin_o    = 2'b00;
    forever begin
      @(posedge mclk_i);
      for (int c = 0; c < 9; c++) begin
        raw_o[c*16 +: 16] <= 16'($urandom);
      end
      pulse8_o <= rstn_i && ($urandom % 4 == 0); // Level drawn fresh each cycle; can stay high
      pulse9_o <= rstn_i && ($urandom % 8 == 0);
      if ($urandom % 16 == 0) bin_o <= 2'($urandom);
    end
  end
endmodule : sensor_model

// File: tb/data_logging_sequencer_bench.sv
`timescale 1ns/1ns
module data_logging_sequencer_bench;
  import logger_pkg::*;
  typedef struct {
    int          due;
    int          kind;
    logic [23:0] disp;
    logic [3:0]  mode;
    logic [3:0]  ctl;
  } note_t;

  logic          mclk_i, rstn_i, hsel, hwrite;
  logic [31:0]   haddr, hwdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   hrdata;
  logic          hready, hresp, p8, p9;
  logic [143:0]  raw;
  logic [1:0]    bin;
  logic [3:0]    ctl, mode;
  display_t      disp;
  note_t         notes[$];
  int            cyc, miscompares, n_tests;
  logic [23:0]   exp_disp;
  logic [3:0]    exp_ctl;

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc <= cyc + 1;

  // Scan periods kept longer than one full table pass
  data_logging_sequencer #(.SCAN_LONG(480), .SCAN_SHORT(80)) dut_u (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .raw_i(raw), .pulse8_i(p8),
    .pulse9_i(p9), .bin_in_i(bin), .ctl_out_o(ctl), .display_o(disp),
    .mode_o(mode));
  sensor_model sens_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .raw_o(raw),
    .pulse8_o(p8), .pulse9_o(p9), .bin_o(bin));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Hold each phase until hready is sampled high; no fixed latency assumed
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_ready

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
  endtask : bus_write

  // Binary inputs noted at the address edge, data taken at the data edge
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] b);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b0;
    wait_ready();
    b = bin;
    htrans <= 2'b00;
    hsel   <= 1'b0;
    wait_ready();
    d = hrdata;
  endtask : bus_read

  task automatic note(input int k, input logic [3:0] m);
    note_t nt;
    nt = '{cyc + 4, k, exp_disp, m, exp_ctl};
    notes.push_back(nt);
    repeat (6) @(posedge mclk_i);
  endtask : note

  // Compares each note once the cycle it is due at has settled
  initial begin
    note_t nt;
    forever begin
      @(posedge mclk_i);
      #1;
      if (notes.size() > 0 && notes[0].due <= cyc) begin
        nt = notes.pop_front();
        check("display", disp, nt.disp);
        if (nt.kind == 1) check("mode", mode, nt.mode);
        check("ctl_out", ctl, nt.ctl);
      end
    end
  end

  initial begin
    int d;
    logic [31:0] rd;
    logic [1:0]  bs;
    rstn_i = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = '0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    exp_ctl = 4'h0;
    void'($urandom(32'h2255));
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    // Every mode, each entered by star then its digit; pointer still 0
    for (int i = 1; i <= 10; i++) begin
      d = i % 10;
      exp_disp = 24'h000000;
      bus_write(REG_KEY, {27'h0, KEY_STAR});
      note(0, 4'h0);
      exp_disp = {4'h0, 4'(d),
                  (d >= 1 && d <= 6) ? 16'hffff : 16'h0000};
      if (d == 0) exp_disp = 24'h000000;
      bus_write(REG_KEY, 32'(d));
      note(1, 4'(d));
    end
    // Control outputs follow software, untouched by unmapped writes
    for (int i = 0; i < 8; i++) begin
      exp_ctl = (i == 7) ? 4'hf : 4'($urandom);
      bus_write(REG_OUTCTL, {28'h0, exp_ctl});
      bus_write(8'h3c, $urandom);
      note(2, 4'h0);
      bus_read(REG_OUTCTL, rd, bs);
      check("outctl_rd", rd, {28'h0, exp_ctl});
    end
    // Interval range and edit refusal while active
    bus_write(REG_CHSEL, 32'h0);
    bus_write(REG_MULT, 32'h0);
    bus_write(REG_OFFS, 32'h0123);
    bus_write(REG_TBLSEL, 32'h0);
    bus_write(REG_TBLPROG, {16'h0, 2'd0, 6'd0, 4'd0, OP_SAMPLE});
    bus_write(REG_TBLINT, 32'h0);
    bus_read(REG_TBLINT, rd, bs);
    check("tbl_int", rd, 32'(MIN_INTERVAL_MIN));
    bus_write(REG_TBLINT, 32'(MAX_INTERVAL_MIN + 1));
    bus_read(REG_TBLINT, rd, bs);
    check("tbl_int", rd, 32'(MIN_INTERVAL_MIN));
    bus_write(REG_TBLINT, 32'(MAX_INTERVAL_MIN));
    bus_read(REG_TBLINT, rd, bs);
    check("tbl_int", rd, 32'(MAX_INTERVAL_MIN));
    bus_write(REG_TBLINT, 32'(MIN_INTERVAL_MIN));
    bus_write(REG_TBLACT, 32'h1);
    bus_write(REG_TBLINT, 32'h5);
    bus_read(REG_TBLINT, rd, bs);
    check("tbl_int", rd, 32'(MIN_INTERVAL_MIN));
    // Sample table on a fixed reading until the first final write
    bus_write(REG_CTRL, 32'h1);
    rd = '0;
    for (int n = 0; n < 1000 && rd[9:0] == 10'd0; n++)
      bus_read(REG_STATUS, rd, bs);
    if (rd[9:0] == 10'd0) begin
      miscompares++;
      report_and_stop();
    end
    check("fin_ptr", {22'h0, rd[9:0]}, 32'h1);
    check("status", {rd[31:10], 10'h0},
          {15'h0, 2'b00, 3'b001, bs, 10'h0});
    bus_write(REG_FINADDR, 32'h0);
    bus_read(REG_FINDATA, rd, bs);
    check("fin_data", rd, 32'h0123);
    bus_read(REG_INDATA, rd, bs);
    check("in_data", rd, 32'h0123);
    // Mode 7 shows the pointer in the data field
    exp_disp = 24'h000000;
    bus_write(REG_KEY, {27'h0, KEY_STAR});
    note(0, 4'h0);
    exp_disp = {8'h07, 16'h0001};
    bus_write(REG_KEY, 32'h7);
    note(1, 4'h7);
    for (int n = 0; n < 100 && notes.size() > 0; n++) @(posedge mclk_i);
    if (notes.size() > 0) miscompares++;
    report_and_stop();
  end
endmodule : data_logging_sequencer_bench
